// ### shared/hpp_pkg.sv
// Purpose: constants for the host parallel bus port
// Assumes: 10 MHz clk_i, host pins asynchronous to it
// Notes:   bus style codes sit on the two mode pins
package hpp_pkg;
	localparam int         ADDR_W       = 10;
	localparam int         DATA_W       = 8;
	localparam logic [1:0] STYLE_PAIR   = 2'h0;
	localparam logic [1:0] STYLE_DSTRB  = 2'h1;
	localparam logic [7:0] RDATA_RST    = 8'h00;
	localparam logic [9:0] ADDR_RST     = 10'h000;
endpackage : hpp_pkg

// ### hdl/hpp_host_port.sv
// Purpose: host parallel bus port, pins to internal register strobes
// Assumes: host pins synchronised by two flip-flops; register file outside
// Notes:   output enable is combinational from synchronised selects
`timescale 1ns/10ps
module hpp_host_port
	import hpp_pkg::*;
(
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                srst_i,
	// host pins
	input  wire logic [ADDR_W-1:0]   addr_i,
	input  wire logic                chip_select_n_i,
	input  wire logic                read_or_data_strobe_n_i,
	input  wire logic                write_or_dir_i,
	input  wire logic [1:0]          bus_style_select_i,
	input  wire logic [DATA_W-1:0]   data_i,
	output logic      [DATA_W-1:0]   data_o,
	output logic                     data_oe_o,
	// internal register side
	output logic      [ADDR_W-1:0]   reg_addr_o,
	output logic                     reg_rd_o,
	output logic                     reg_wr_o,
	output logic      [DATA_W-1:0]   reg_wdata_o,
	input  wire logic [DATA_W-1:0]   reg_rdata_i
);
	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [ADDR_W+DATA_W+5:0] meta_r;
	logic [ADDR_W+DATA_W+5:0] sync_r;
	always_ff @(posedge clk_i) begin
		meta_r <= {addr_i, data_i, chip_select_n_i, read_or_data_strobe_n_i, write_or_dir_i,
			bus_style_select_i, 1'b0};
		sync_r <= meta_r;
	end

	wire [ADDR_W-1:0] s_addr  = sync_r[ADDR_W+DATA_W+5:DATA_W+6];
	wire [DATA_W-1:0] s_data  = sync_r[DATA_W+5:6];
	wire              s_cs_n  = sync_r[5];
	wire              s_rds_n = sync_r[4];
	wire              s_wrd   = sync_r[3];
	wire [1:0]        s_style = sync_r[2:1];

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	// reserved style codes act as no style: bus stays idle
	wire style_pair = (s_style == STYLE_PAIR);
	wire style_ds   = (s_style == STYLE_DSTRB);
	wire sel        = !s_cs_n && !srst_i;
	wire rd_act     = sel && ((style_pair && !s_rds_n) || (style_ds && !s_rds_n && s_wrd));
	wire wr_lvl     = sel && ((style_pair && !s_wrd) || (style_ds && !s_rds_n && !s_wrd));

	logic wr_lvl_r;
	logic rd_act_r;
	logic rd_hold_r;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_lvl_r <= 1'b0;
			rd_act_r <= 1'b0;
			rd_hold_r <= 1'b0;
		end else begin
			wr_lvl_r <= wr_lvl;
			rd_act_r <= rd_act;
			rd_hold_r <= rd_act && rd_act_r;
		end
	end

	// write taken at the strobe's trailing (rising) edge; cs must still be low
	wire wr_fire = wr_lvl_r && !wr_lvl && sel;

	// ----------------------------------------
	// register side and data output
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			reg_addr_o  <= ADDR_RST;
			reg_wdata_o <= RDATA_RST;
			data_o      <= RDATA_RST;
			reg_wr_o    <= 1'b0;
		end else begin
			reg_wr_o <= wr_fire;
			if (sel)
				reg_addr_o <= s_addr;
			if (wr_lvl)
				reg_wdata_o <= s_data;
			// address is registered one clock before its contents are taken
			if (rd_act && rd_act_r)
				data_o <= reg_rdata_i;
		end
	end

	assign reg_rd_o  = rd_act && rd_act_r && !rd_hold_r;
	// drive only once data_o holds the addressed byte; cs high cuts it two clocks after the pin
	assign data_oe_o = rd_act && rd_hold_r && !srst_i;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence wr_trailing;
		wr_lvl_r && !wr_lvl && sel;
	endsequence

	sequence rd_pair_cyc;
		style_pair && sel && !s_rds_n;
	endsequence

	sequence rd_start;
		rd_act && !rd_act_r;
	endsequence

	sequence wr_open;
		wr_lvl && !wr_lvl_r;
	endsequence

	a_oe_cs_high: assert property (@(posedge clk_i) disable iff (srst_i) s_cs_n |-> !data_oe_o)
		else $error("data driven while deselected");
	a_oe_reset: assert property (@(posedge clk_i) srst_i |-> !data_oe_o)
		else $error("data driven in reset");
	a_no_write_desel: assert property (@(posedge clk_i) disable iff (srst_i) s_cs_n |=> !reg_wr_o)
		else $error("write while deselected");
	a_write_edge: assert property (@(posedge clk_i) disable iff (srst_i) wr_trailing |=> reg_wr_o)
		else $error("write strobe edge missed");
	a_write_data: assert property (@(posedge clk_i) disable iff (srst_i)
		wr_lvl ##1 wr_trailing |=> reg_wdata_o == $past(s_data, 2))
		else $error("write data wrong");
	a_read_drive: assert property (@(posedge clk_i) disable iff (srst_i)
		rd_pair_cyc ##1 rd_pair_cyc ##1 rd_pair_cyc |-> data_oe_o)
		else $error("read not driven");
	a_addr_track: assert property (@(posedge clk_i) disable iff (srst_i) sel |=> reg_addr_o == $past(s_addr))
		else $error("address not captured");
	a_reserved_idle: assert property (@(posedge clk_i) disable iff (srst_i)
		s_style[1] |-> !data_oe_o && !wr_fire)
		else $error("reserved style active");

	// ----------------------------------------
	// read path checks
	// ----------------------------------------
	a_rd_pulse_one: assert property (
		@(posedge clk_i) disable iff (srst_i) reg_rd_o |=> !reg_rd_o)
		else $error("read pulse longer than one clock");

	a_rd_pulse_cause: assert property (
		@(posedge clk_i) disable iff (srst_i) reg_rd_o |-> rd_act && sel)
		else $error("read pulse without read");

	a_rd_pulse_follows: assert property (
		@(posedge clk_i) disable iff (srst_i) rd_start ##1 rd_act |-> reg_rd_o)
		else $error("read pulse missing");

	a_oe_after_pulse: assert property (
		@(posedge clk_i) disable iff (srst_i) $rose(data_oe_o) |-> $past(reg_rd_o))
		else $error("drive before register read");

	a_rdata_loaded: assert property (
		@(posedge clk_i) disable iff (srst_i) data_oe_o |-> data_o == $past(reg_rdata_i))
		else $error("driven data not the addressed byte");

	a_data_hold: assert property (
		@(posedge clk_i) disable iff (srst_i) !rd_act |=> $stable(data_o))
		else $error("read data changed outside a read");

	a_ds_read_dir: assert property (
		@(posedge clk_i) disable iff (srst_i) style_ds && data_oe_o |-> s_wrd)
		else $error("data strobe read with write direction");

	a_oe_style_ok: assert property (
		@(posedge clk_i) disable iff (srst_i) data_oe_o |-> style_pair || style_ds)
		else $error("drive under reserved style");

	a_rd_reserved: assert property (
		@(posedge clk_i) disable iff (srst_i) s_style[1] |-> !reg_rd_o)
		else $error("read under reserved style");

	// ----------------------------------------
	// write path checks
	// ----------------------------------------
	a_wr_pulse_one: assert property (
		@(posedge clk_i) disable iff (srst_i) reg_wr_o |=> !reg_wr_o)
		else $error("write pulse longer than one clock");

	a_wr_cause: assert property (
		@(posedge clk_i) disable iff (srst_i) reg_wr_o |-> $past(wr_fire))
		else $error("write without trailing strobe");

	a_wr_no_early: assert property (
		@(posedge clk_i) disable iff (srst_i) wr_open |=> !reg_wr_o)
		else $error("write taken at leading strobe edge");

	a_wr_addr_stable: assert property (
		@(posedge clk_i) disable iff (srst_i) reg_wr_o |-> reg_addr_o == $past(s_addr))
		else $error("write address wrong");

	a_wdata_hold: assert property (
		@(posedge clk_i) disable iff (srst_i) !wr_lvl |=> $stable(reg_wdata_o))
		else $error("write data changed outside a write");

	a_wr_reserved: assert property (
		@(posedge clk_i) disable iff (srst_i) s_style[1] && $past(s_style[1]) |=> !reg_wr_o)
		else $error("write under reserved style");

	// ----------------------------------------
	// select and reset checks
	// ----------------------------------------
	a_rd_desel: assert property (
		@(posedge clk_i) disable iff (srst_i) s_cs_n |-> !reg_rd_o)
		else $error("read pulse while deselected");

	a_wr_needs_sel: assert property (
		@(posedge clk_i) disable iff (srst_i) reg_wr_o |-> $past(sel))
		else $error("write without select");

	a_oe_drop_cs: assert property (
		@(posedge clk_i) disable iff (srst_i) s_cs_n |=> !data_oe_o)
		else $error("drive kept after deselect");

	a_addr_hold: assert property (
		@(posedge clk_i) disable iff (srst_i) !sel |=> $stable(reg_addr_o))
		else $error("address moved while deselected");

	a_reset_outputs: assert property (
		@(posedge clk_i) $past(srst_i) |-> data_o == RDATA_RST && !reg_wr_o)
		else $error("outputs not cleared by reset");

	a_reset_addr: assert property (
		@(posedge clk_i) $past(srst_i) |-> reg_addr_o == ADDR_RST && reg_wdata_o == RDATA_RST)
		else $error("register side not cleared by reset");

	a_reset_no_read: assert property (
		@(posedge clk_i) srst_i |-> !reg_rd_o)
		else $error("read pulse in reset");
endmodule : hpp_host_port

// ### tb/hpp_regfile_model.sv
// Purpose: register file behind the port
// Assumes: combinational read
// Notes:   behavioural
`timescale 1ns/10ps
module hpp_regfile_model
	import hpp_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              wr_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	output logic      [DATA_W-1:0] rdata_o
);
	logic [7:0] mem_r [1024] = '{default: 8'h00};
	assign rdata_o = mem_r[addr_i];
	always @(posedge clk_i) if (wr_i) mem_r[addr_i] <= wdata_i;
endmodule : hpp_regfile_model

// ### tb/hpp_host_port_tb.sv
// Purpose: bench for hpp_host_port
// Assumes: pins held several clocks
// Notes:   reads queued, popped when drive starts
`timescale 1ns/10ps
module hpp_host_port_tb;
	import hpp_pkg::*;
	logic clk = 0, srst = 1, cs_n = 0, sb_n = 0, wod = 1, oe_q = 0, rr, rw, oe;
	logic [1:0] sty = 2'h0;
	logic [9:0] a = 10'h000, ra, ad;
	logic [7:0] d = 8'h00, rd, d_o, wdat, wd, q[$], mem [1024] = '{default: 8'h00};
	int num_errors = 0, checked = 0, seed = 32'h78b5, rd_cnt = 0, wr_cnt = 0;
	initial forever #50 clk = ~clk;
	hpp_host_port dut_u (.clk_i(clk), .srst_i(srst), .addr_i(a), .chip_select_n_i(cs_n),
		.read_or_data_strobe_n_i(sb_n), .write_or_dir_i(wod), .bus_style_select_i(sty), .data_i(d),
		.data_o(d_o), .data_oe_o(oe), .reg_addr_o(ra), .reg_rd_o(rr), .reg_wr_o(rw), .reg_wdata_o(wdat),
		.reg_rdata_i(rd));
	hpp_regfile_model rf_u (.clk_i(clk), .wr_i(rw), .addr_i(ra), .wdata_i(wdat), .rdata_o(rd));
	task automatic chk(input logic [7:0] s, e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic acc(input logic [1:0] st, input logic c, w, input logic [9:0] ad, input logic [7:0] v);
		sty <= st; a <= ad; d <= v; cs_n <= c; wod <= ~w; sb_n <= (st == STYLE_PAIR) ? w : 1'b0;
		if (!c && !st[1] && !w) q.push_back(mem[ad]);
		if (!c && !st[1] && w) mem[ad] = v;
		repeat (5) @(posedge clk);
		// direction held past the data strobe rise
		sb_n <= 1'b1;
		if (st != STYLE_DSTRB) wod <= 1'b1;
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		wod <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : acc
	task automatic close_out;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	always @(negedge clk) begin
		if (oe === 1'b1 && oe_q === 1'b0) begin
			if (q.size() == 0) chk(8'h01, 8'h00);
			else chk(d_o, q.pop_front());
		end
		if (rr === 1'b1) rd_cnt++;
		if (rw === 1'b1) wr_cnt++;
		oe_q <= oe;
	end
	initial begin
		@(posedge clk);
		cs_n <= 1'b1;
		sb_n <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 16; i++) begin
			ad = $random(seed);
			wd = $random(seed);
			acc(i[1:0], i[2], 1'b1, ad, wd);
			acc({1'b0, i[0]}, 1'b0, 1'b0, ad, 8'h00);
		end
		chk(8'(q.size()), 8'h00);
		chk(8'(rd_cnt), 8'h10);
		chk(8'(wr_cnt), 8'h04);
		close_out;
	end
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		close_out;
	end
endmodule : hpp_host_port_tb
